//--- hdl/rmml_regs.sv
`timescale 1ns/1ps
// Overview of operation
// - validation off, full-wave select picks half-wave (0) or full-wave (1) ring detect.
// - validation on, select 0: ring flag follows validated ring envelope.
// - validation on, select 1: ring flag is threshold one-shot lasting about five seconds.
// - dropout bit at position 1 reads 0 normally, 1 after dropout detected.
// - receive monitor path scaled linearly by 8-bit receive level code.
// - receive level code zero fully mutes receive monitor contribution.
// - transmit monitor path scaled the same way; zero mutes it.
module rmml_regs import rmml_pkg::*; #(
   parameter int ONESHOT_CYC = ONESHOT_CYCLES,
   parameter int W           = SAMPLE_W
) (
   input  wire logic                clk,
   input  wire logic                sys_rst,
   input  wire logic                hsel,
   input  wire logic [31:0]         haddr,
   input  wire logic [1:0]          htrans,
   input  wire logic                hwrite,
   input  wire logic [2:0]          hsize,
   input  wire logic [31:0]         hwdata,
   input  wire logic                hready,
   output logic                     hreadyout,
   output logic [31:0]              hrdata,
   output logic                     hresp,
   input  wire rmml_ring_in_t       ring_in,
   input  wire logic                dropout_detect,
   input  wire logic signed [W-1:0] rx_monitor_in,
   input  wire logic signed [W-1:0] tx_monitor_in,
   output logic                     ring_detect_flag,
   output logic signed [W-1:0]      call_progress_out,
   output logic                     irq
);

   if (ONESHOT_CYC < 2) $error("one-shot length too short");

   // ***************************************
   // register state
   // ***************************************
   logic                  full_wave_ring_select;
   logic                  ring_validation_enable;
   logic                  line_dropout_flag;
   logic [7:0]            monitor_rx_level;
   logic [7:0]            monitor_tx_level;
   logic [IRQ_BITS-1:0]   irq_status;
   logic [IRQ_BITS-1:0]   irq_mask;
   logic                  ring_flag_d;

   // ***************************************
   // bus phase tracking
   // ***************************************
   rmml_bus_state_t       state;
   rmml_bus_state_t       next_state;
   rmml_req_t             req;
   logic                  accept;
   logic                  wr_en;

   assign accept = hsel && htrans[1] && hready && (state != ST_READ);
   assign wr_en  = (state == ST_WRITE) && req.mapped;

   always_comb begin
      case (state)
         ST_READ: next_state = ST_IDLE;
         default: begin
            if (accept && hwrite)  next_state = ST_WRITE;
            else if (accept)       next_state = ST_READ;
            else                   next_state = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         state <= ST_IDLE;
         req   <= '0;
      end else begin
         state <= next_state;
         if (accept) begin
            req.mapped <= (haddr[31:8] == 24'h0) && (hsize == 3'h2);
            req.addr   <= haddr[7:0];
         end
      end
   end

   // ***************************************
   // address decode
   // ***************************************
   wire hit_ring_mode = req.addr == byte_addr(IDX_RING_MODE);
   wire hit_dropout   = req.addr == byte_addr(IDX_DROPOUT);
   wire hit_mon_rx    = req.addr == byte_addr(IDX_MON_RX);
   wire hit_mon_tx    = req.addr == byte_addr(IDX_MON_TX);
   wire hit_irq_stat  = req.addr == byte_addr(IDX_IRQ_STATUS);
   wire hit_irq_mask  = req.addr == byte_addr(IDX_IRQ_MASK);
   wire hit_ring_cfg  = req.addr == byte_addr(IDX_RING_CFG);

   logic [31:0] rd_data;

   always_comb begin
      rd_data = 32'h0;
      if (!req.mapped) begin
         rd_data = 32'h0;
      end else if (hit_ring_mode) begin
         rd_data[POS_FULL_WAVE] = full_wave_ring_select;
      end else if (hit_dropout) begin
         rd_data[POS_DROPOUT] = line_dropout_flag;
      end else if (hit_mon_rx) begin
         rd_data[7:0] = monitor_rx_level;
      end else if (hit_mon_tx) begin
         rd_data[7:0] = monitor_tx_level;
      end else if (hit_irq_stat) begin
         rd_data[IRQ_BITS-1:0] = irq_status;
      end else if (hit_irq_mask) begin
         rd_data[IRQ_BITS-1:0] = irq_mask;
      end else if (hit_ring_cfg) begin
         rd_data[POS_RING_VALID] = ring_validation_enable;
      end
   end

   // ***************************************
   // bus outputs
   // ***************************************
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         hreadyout <= 1'b1;
         hrdata    <= 32'h0;
         hresp     <= 1'b0;
      end else begin
         hreadyout <= (next_state != ST_READ);
         hresp     <= 1'b0;
         if (state == ST_READ) hrdata <= rd_data;
      end
   end

   a_read_wait: assert property (@(posedge clk) disable iff (sys_rst)
      accept && !hwrite |=> !hreadyout ##1 hreadyout)
      else $error("read wait state wrong");
   a_write_ready: assert property (@(posedge clk) disable iff (sys_rst)
      accept && hwrite |=> hreadyout)
      else $error("write stalled the bus");
   a_unmapped_read: assert property (@(posedge clk) disable iff (sys_rst)
      state == ST_READ && !req.mapped |=> hrdata == 32'h0)
      else $error("unmapped read not zero");
   a_dropout_read: assert property (@(posedge clk) disable iff (sys_rst)
      state == ST_READ && req.mapped && hit_dropout
      |=> hrdata == {30'h0, $past(line_dropout_flag), 1'b0})
      else $error("dropout read wrong");
   a_mode_reserved: assert property (@(posedge clk) disable iff (sys_rst)
      state == ST_READ && req.mapped && hit_ring_mode |=> hrdata[31:2] == 30'h0 && !hrdata[0])
      else $error("reserved mode bits not zero");

   // ***************************************
   // control registers
   // ***************************************
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         full_wave_ring_select  <= RST_FULL_WAVE;
         ring_validation_enable <= RST_RING_VALID;
         monitor_rx_level       <= RST_MON_RX;
         monitor_tx_level       <= RST_MON_TX;
         irq_mask               <= RST_IRQ_MASK;
      end else if (wr_en) begin
         if (hit_ring_mode) full_wave_ring_select <= hwdata[POS_FULL_WAVE];
         if (hit_ring_cfg)  ring_validation_enable <= hwdata[POS_RING_VALID];
         if (hit_mon_rx)    monitor_rx_level <= hwdata[7:0];
         if (hit_mon_tx)    monitor_tx_level <= hwdata[7:0];
         if (hit_irq_mask)  irq_mask <= hwdata[IRQ_BITS-1:0];
      end
   end

   a_mode_write: assert property (@(posedge clk) disable iff (sys_rst)
      wr_en && hit_ring_mode |=> full_wave_ring_select == $past(hwdata[POS_FULL_WAVE]))
      else $error("full-wave select not written");
   a_valid_write: assert property (@(posedge clk) disable iff (sys_rst)
      wr_en && hit_ring_cfg |=> ring_validation_enable == $past(hwdata[POS_RING_VALID]))
      else $error("validation enable not written");
   a_rx_level_write: assert property (@(posedge clk) disable iff (sys_rst)
      wr_en && hit_mon_rx |=> monitor_rx_level == $past(hwdata[7:0]))
      else $error("receive level not written");
   a_tx_level_write: assert property (@(posedge clk) disable iff (sys_rst)
      wr_en && hit_mon_tx |=> monitor_tx_level == $past(hwdata[7:0]))
      else $error("transmit level not written");

   // ***************************************
   // dropout status, hardware set only
   // ***************************************
   always_ff @(posedge clk) begin
      if (sys_rst)             line_dropout_flag <= 1'b0;
      else if (dropout_detect) line_dropout_flag <= 1'b1;
   end

   a_dropout_set: assert property (@(posedge clk) disable iff (sys_rst)
      dropout_detect |=> line_dropout_flag)
      else $error("dropout not reported");
   a_dropout_hold: assert property (@(posedge clk) disable iff (sys_rst)
      line_dropout_flag |=> line_dropout_flag)
      else $error("dropout flag cleared");
   a_dropout_source: assert property (@(posedge clk) disable iff (sys_rst)
      !line_dropout_flag && !dropout_detect |=> !line_dropout_flag)
      else $error("dropout set without detection");

   // ***************************************
   // ring detect select
   // ***************************************
   rmml_ring_sel #(
      .ONESHOT_CYC (ONESHOT_CYC)
   ) u_ring (
      .clk                    (clk),
      .sys_rst                (sys_rst),
      .full_wave_ring_select  (full_wave_ring_select),
      .ring_validation_enable (ring_validation_enable),
      .ring_in                (ring_in),
      .ring_detect_flag       (ring_detect_flag)
   );

   // ***************************************
   // interrupt status and mask
   // ***************************************
   logic [IRQ_BITS-1:0] irq_event;
   logic [IRQ_BITS-1:0] irq_clear;
   logic [IRQ_BITS-1:0] next_irq_status;

   assign irq_event[POS_IRQ_RING] = ring_detect_flag && !ring_flag_d;
   assign irq_event[POS_IRQ_DROP] = dropout_detect && !line_dropout_flag;
   assign irq_clear       = (wr_en && hit_irq_stat) ? hwdata[IRQ_BITS-1:0] : '0;
   assign next_irq_status = (irq_status & ~irq_clear) | irq_event;

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         irq_status  <= '0;
         ring_flag_d <= 1'b0;
         irq         <= 1'b0;
      end else begin
         irq_status  <= next_irq_status;
         ring_flag_d <= ring_detect_flag;
         irq         <= |(next_irq_status & irq_mask);
      end
   end

   a_irq_level: assert property (@(posedge clk) disable iff (sys_rst)
      ##1 irq == |($past(next_irq_status) & $past(irq_mask)))
      else $error("interrupt level wrong");
   a_irq_set_wins: assert property (@(posedge clk) disable iff (sys_rst)
      irq_event[POS_IRQ_RING] |=> irq_status[POS_IRQ_RING])
      else $error("ring event lost");
   a_dropout_irq: assert property (@(posedge clk) disable iff (sys_rst)
      dropout_detect && !line_dropout_flag |=> irq_status[POS_IRQ_DROP])
      else $error("dropout event lost");
   a_irq_clear: assert property (@(posedge clk) disable iff (sys_rst)
      wr_en && hit_irq_stat && hwdata[POS_IRQ_DROP] && !irq_event[POS_IRQ_DROP]
      |=> !irq_status[POS_IRQ_DROP])
      else $error("status bit not cleared");
   a_irq_masked: assert property (@(posedge clk) disable iff (sys_rst)
      irq_mask == '0 |=> !irq)
      else $error("masked interrupt raised");

   // ***************************************
   // call progress monitor paths
   // ***************************************
   logic signed [W-1:0] rx_scaled;
   logic signed [W-1:0] tx_scaled;
   logic signed [W:0]   mon_sum;
   logic signed [W-1:0] next_out;

   rmml_level_scale #(
      .W (W)
   ) u_rx_scale (
      .clk     (clk),
      .sys_rst (sys_rst),
      .sample  (rx_monitor_in),
      .level   (monitor_rx_level),
      .scaled  (rx_scaled)
   );

   rmml_level_scale #(
      .W (W)
   ) u_tx_scale (
      .clk     (clk),
      .sys_rst (sys_rst),
      .sample  (tx_monitor_in),
      .level   (monitor_tx_level),
      .scaled  (tx_scaled)
   );

   assign mon_sum  = {rx_scaled[W-1], rx_scaled} + {tx_scaled[W-1], tx_scaled};
   assign next_out = (mon_sum[W] == mon_sum[W-1]) ? mon_sum[W-1:0] :
                     {mon_sum[W], {(W-1){~mon_sum[W]}}};

   always_ff @(posedge clk) begin
      if (sys_rst) call_progress_out <= '0;
      else         call_progress_out <= next_out;
   end

   a_both_muted: assert property (@(posedge clk) disable iff (sys_rst)
      monitor_rx_level == 8'h00 && monitor_tx_level == 8'h00 ##1
      monitor_rx_level == 8'h00 && monitor_tx_level == 8'h00
      |=> call_progress_out == '0)
      else $error("muted paths leak to output");
   a_tx_unity: assert property (@(posedge clk) disable iff (sys_rst)
      monitor_rx_level == 8'h00 ##1 monitor_rx_level == 8'h00 &&
      $past(monitor_tx_level) == 8'h40
      |=> call_progress_out == $past(tx_monitor_in, 2))
      else $error("transmit unity path wrong");

endmodule : rmml_regs

//--- hdl/rmml_pkg.sv
package rmml_pkg;

   // ***************************************
   // register indices, byte address = 4*idx
   // ***************************************
   localparam logic [7:0] IDX_RING_MODE   = 8'h12;
   localparam logic [7:0] IDX_DROPOUT     = 8'h13;
   localparam logic [7:0] IDX_MON_RX      = 8'h14;
   localparam logic [7:0] IDX_MON_TX      = 8'h15;
   localparam logic [7:0] IDX_IRQ_STATUS  = 8'h20;
   localparam logic [7:0] IDX_IRQ_MASK    = 8'h21;
   localparam logic [7:0] IDX_RING_CFG    = 8'h22;

   // ***************************************
   // field positions and reset values
   // ***************************************
   localparam int         POS_FULL_WAVE   = 1;
   localparam int         POS_DROPOUT     = 1;
   localparam int         POS_RING_VALID  = 0;
   localparam int         POS_IRQ_RING    = 0;
   localparam int         POS_IRQ_DROP    = 1;
   localparam int         IRQ_BITS        = 2;
   localparam logic       RST_FULL_WAVE   = 1'b0;
   localparam logic       RST_RING_VALID  = 1'b0;
   localparam logic [7:0] RST_MON_RX      = 8'h00;
   localparam logic [7:0] RST_MON_TX      = 8'h00;
   localparam logic [1:0] RST_IRQ_MASK    = 2'h0;

   // ***************************************
   // timing and scaling
   // ***************************************
   localparam longint     CLK_HZ          = 20_000_000;
   localparam longint     ONESHOT_TIME_MS = 5000;
   localparam int         ONESHOT_CYCLES  = int'(ONESHOT_TIME_MS * CLK_HZ / 1000);
   localparam int         UNITY_SHIFT     = 6;
   localparam int         SAMPLE_W        = 16;

   // ***************************************
   // types
   // ***************************************
   typedef enum logic [1:0] {ST_IDLE, ST_WRITE, ST_READ} rmml_bus_state_t;

   typedef struct packed {
      logic half_wave;
      logic full_wave;
      logic envelope;
      logic threshold_cross;
   } rmml_ring_in_t;

   typedef struct packed {
      logic       mapped;
      logic [7:0] addr;
   } rmml_req_t;

   function automatic logic [7:0] byte_addr(input logic [7:0] idx);
      byte_addr = {idx[5:0], 2'b00};
   endfunction : byte_addr

endpackage : rmml_pkg

//--- hdl/rmml_ring_sel.sv
`timescale 1ns/1ps
module rmml_ring_sel import rmml_pkg::*; #(
   parameter int ONESHOT_CYC = ONESHOT_CYCLES
) (
   input  wire logic          clk,
   input  wire logic          sys_rst,
   input  wire logic          full_wave_ring_select,
   input  wire logic          ring_validation_enable,
   input  wire rmml_ring_in_t ring_in,
   output logic               ring_detect_flag
);

   if (ONESHOT_CYC < 2) $error("one-shot length too short");

   // ***************************************
   // one-shot timer
   // ***************************************
   logic        shot_mode;
   logic        shot_active;
   logic [31:0] shot_cnt;
   logic        next_flag;

   assign shot_mode = ring_validation_enable & full_wave_ring_select;

   always_ff @(posedge clk) begin
      if (sys_rst || !shot_mode) begin
         shot_active <= 1'b0;
         shot_cnt    <= 32'h0;
      end else if (!shot_active && ring_in.threshold_cross) begin
         shot_active <= 1'b1;
         shot_cnt    <= 32'(ONESHOT_CYC - 1);
      end else if (shot_active) begin
         shot_active <= (shot_cnt != 32'h0);
         shot_cnt    <= (shot_cnt != 32'h0) ? shot_cnt - 32'h1 : 32'h0;
      end
   end

   // ***************************************
   // status source select
   // ***************************************
   always_comb begin
      case ({ring_validation_enable, full_wave_ring_select})
         2'b00:   next_flag = ring_in.half_wave;
         2'b01:   next_flag = ring_in.full_wave;
         2'b10:   next_flag = ring_in.envelope;
         default: next_flag = shot_active;
      endcase
   end

   always_ff @(posedge clk) begin
      if (sys_rst) ring_detect_flag <= 1'b0;
      else         ring_detect_flag <= next_flag;
   end

   a_half_wave_mode: assert property (@(posedge clk) disable iff (sys_rst)
      !ring_validation_enable && !full_wave_ring_select
      |=> ring_detect_flag == $past(ring_in.half_wave))
      else $error("ring flag not half-wave");
   a_full_wave_mode: assert property (@(posedge clk) disable iff (sys_rst)
      !ring_validation_enable && full_wave_ring_select
      |=> ring_detect_flag == $past(ring_in.full_wave))
      else $error("ring flag not full-wave");
   a_envelope_track: assert property (@(posedge clk) disable iff (sys_rst)
      ring_validation_enable && !full_wave_ring_select
      |=> ring_detect_flag == $past(ring_in.envelope))
      else $error("ring flag not envelope");
   a_oneshot_start: assert property (@(posedge clk) disable iff (sys_rst)
      shot_mode && !shot_active && ring_in.threshold_cross ##1 shot_mode
      |=> ring_detect_flag)
      else $error("one-shot did not start");
   a_oneshot_length: assert property (@(posedge clk) disable iff (sys_rst)
      shot_cnt <= 32'(ONESHOT_CYC - 1) && (shot_active || shot_cnt == 32'h0))
      else $error("one-shot count out of range");

endmodule : rmml_ring_sel

//--- hdl/rmml_level_scale.sv
`timescale 1ns/1ps
module rmml_level_scale import rmml_pkg::*; #(
   parameter int W = SAMPLE_W
) (
   input  wire logic                clk,
   input  wire logic                sys_rst,
   input  wire logic signed [W-1:0] sample,
   input  wire logic        [7:0]   level,
   output logic signed      [W-1:0] scaled
);

   if (W < 8 || W > 32) $error("sample width not supported");

   localparam int PW = W + 9;
   localparam logic signed [PW-1:0] HI = PW'((64'sd1 <<< (W - 1)) - 64'sd1);
   localparam logic signed [PW-1:0] LO = ~HI;

   // ***************************************
   // linear gain, code/64, saturated
   // ***************************************
   logic signed [PW-1:0] prod;
   logic signed [PW-1:0] shifted;
   logic signed [W-1:0]  next_scaled;

   assign prod        = PW'(sample) * $signed({1'b0, level});
   assign shifted     = prod >>> UNITY_SHIFT;
   assign next_scaled = (shifted > HI) ? HI[W-1:0] :
                        (shifted < LO) ? LO[W-1:0] : shifted[W-1:0];

   always_ff @(posedge clk) begin
      if (sys_rst) scaled <= '0;
      else         scaled <= next_scaled;
   end

   a_mute_zero: assert property (@(posedge clk) disable iff (sys_rst)
      level == 8'h00 |=> scaled == '0)
      else $error("mute code passed signal");
   a_unity_gain: assert property (@(posedge clk) disable iff (sys_rst)
      level == 8'h40 |=> scaled == $past(sample))
      else $error("unity code not unity");
   a_half_gain: assert property (@(posedge clk) disable iff (sys_rst)
      level == 8'h20 |=> scaled == W'($past(sample) >>> 1))
      else $error("-6 dB code wrong");

endmodule : rmml_level_scale

//--- dv/rmml_line_model.sv
`timescale 1ns/1ps
// ***************************************
// line-side front end seen by the block
// ***************************************
module rmml_line_model import rmml_pkg::*; (
   input  wire logic                       clk,
   input  wire logic [2:0]                 ring_lvl,
   input  wire logic                       cross_req,
   input  wire logic                       drop_req,
   input  wire logic signed [SAMPLE_W-1:0] rx_amp,
   input  wire logic signed [SAMPLE_W-1:0] tx_amp,
   output rmml_ring_in_t                   ring_in,
   output logic                            dropout_detect,
   output logic signed [SAMPLE_W-1:0]      rx_sample,
   output logic signed [SAMPLE_W-1:0]      tx_sample
);
   logic cross_q;

   initial begin
      cross_q        = 1'b0;
      ring_in        = '0;
      dropout_detect = 1'b0;
      rx_sample      = '0;
      tx_sample      = '0;
   end

   // half, full, envelope levels; crossing is a one-cycle pulse
   always @(posedge clk) begin
      cross_q        <= cross_req;
      ring_in        <= {ring_lvl, cross_req & ~cross_q};
      dropout_detect <= drop_req;
      rx_sample      <= rx_amp;
      tx_sample      <= tx_amp;
   end
endmodule : rmml_line_model

//--- dv/ring_mode_and_monitor_level_regs_tb.sv
`timescale 1ns/1ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin n_mismatch++; $display("unexpected at %0t ns: got %h expected %h", $time, (g), (e)); end end
module ring_mode_and_monitor_level_regs_tb import rmml_pkg::*;;
   localparam int OS = 20;
   logic clk = 1'b0, sys_rst = 1'b1, hsel = 1'b0, hwrite = 1'b0;
   logic [31:0] haddr = '0, hwdata = '0, hrdata, rdv;
   logic [1:0] htrans = 2'b00;
   logic [2:0] hsize = 3'b010, ring_lvl = 3'b000;
   logic hreadyout, hresp, ring_detect_flag, irq, dropout_detect;
   logic cross_req = 1'b0, drop_req = 1'b0;
   logic signed [SAMPLE_W-1:0] rx_amp = '0, tx_amp = '0, rx_s, tx_s, call_progress_out;
   rmml_ring_in_t ring_in;
   int n_mismatch = 0, compares = 0, cnt, m;
   logic [7:0] codes [6] = '{8'h7f, 8'h40, 8'h20, 8'h10, 8'h00, 8'h30};

   always #25 clk = ~clk;

   rmml_regs #(.ONESHOT_CYC(OS), .W(SAMPLE_W)) dut (
      .clk(clk), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .ring_in(ring_in),
      .dropout_detect(dropout_detect), .rx_monitor_in(rx_s), .tx_monitor_in(tx_s),
      .ring_detect_flag(ring_detect_flag), .call_progress_out(call_progress_out), .irq(irq));

   rmml_line_model line (
      .clk(clk), .ring_lvl(ring_lvl), .cross_req(cross_req), .drop_req(drop_req),
      .rx_amp(rx_amp), .tx_amp(tx_amp), .ring_in(ring_in),
      .dropout_detect(dropout_detect), .rx_sample(rx_s), .tx_sample(tx_s));

   // ***************************************
   // verdict
   // ***************************************
   task automatic report_and_stop;
      $display("mismatches %0d, comparisons %0d", n_mismatch, compares);
      if (n_mismatch == 0 && compares > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : report_and_stop

   // ***************************************
   // ahb-lite single word transfers
   // ***************************************
   task automatic wait_ready;
      int n;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (hreadyout !== 1'b1 && n < 50);
      if (hreadyout !== 1'b1) begin
         n_mismatch++;
         $display("unexpected at %0t ns: bus never ready", $time);
         report_and_stop();
      end
   endtask : wait_ready

   task automatic xfer(input logic [31:0] a, input logic wr, input logic [31:0] wd);
      hsel   <= 1'b1;
      haddr  <= a;
      htrans <= 2'b10;
      hwrite <= wr;
      hsize  <= 3'b010;
      wait_ready();
      htrans <= 2'b00;
      hwdata <= wd;
      wait_ready();
      rdv = hrdata;
      `CHK(hresp, 1'b0)
   endtask : xfer

   task automatic wr(input logic [7:0] idx, input logic [31:0] d);
      xfer({22'h0, idx, 2'b00}, 1'b1, d);
   endtask : wr

   task automatic rd(input logic [7:0] idx);
      xfer({22'h0, idx, 2'b00}, 1'b0, 32'h0);
   endtask : rd

   task automatic tick(input int n);
      repeat (n) @(posedge clk);
   endtask : tick

   function automatic logic [15:0] scale(input int amp, input int code);
      int v;
      v = (amp * code) >>> 6;
      if (v > 32767) v = 32767;
      if (v < -32768) v = -32768;
      return v[15:0];
   endfunction : scale

   // ***************************************
   // scenarios
   // ***************************************
   initial begin
      tick(3);
      sys_rst <= 1'b0;
      tick(2);
      rd(IDX_RING_MODE);  `CHK(rdv[1], 1'b0)
      rd(IDX_DROPOUT);    `CHK(rdv[1], 1'b0)
      rd(IDX_MON_RX);     `CHK(rdv, 32'h0)
      rd(IDX_MON_TX);     `CHK(rdv, 32'h0)
      rd(IDX_IRQ_MASK);   `CHK(rdv, 32'h0)
      // unmapped place: write lost, read zero
      xfer(32'h0000_1050, 1'b1, 32'h0000_00aa);
      xfer(32'h0000_1050, 1'b0, 32'h0);   `CHK(rdv, 32'h0)
      rd(IDX_MON_RX);     `CHK(rdv, 32'h0)
      // ring source per mode: half, full, envelope
      for (m = 0; m < 3; m++) begin
         wr(IDX_RING_MODE, {30'h0, m[0], 1'b0});
         wr(IDX_RING_CFG, {31'h0, m[1]});
         rd(IDX_RING_MODE);  `CHK(rdv[1], m[0])
         ring_lvl <= 3'b100 >> m;
         tick(4);
         `CHK(ring_detect_flag, 1'b1)
         ring_lvl <= ~(3'b100 >> m);
         tick(4);
         `CHK(ring_detect_flag, 1'b0)
      end
      ring_lvl <= 3'b000;
      // one-shot on crossing, second crossing inside ignored
      wr(IDX_RING_MODE, 32'h2);
      tick(3);
      `CHK(ring_detect_flag, 1'b0)
      cross_req <= 1'b1;
      tick(1);
      cross_req <= 1'b0;
      cnt = 0;
      while (ring_detect_flag !== 1'b1 && cnt < 10) begin tick(1); cnt++; end
      cnt = 0;
      while (ring_detect_flag === 1'b1 && cnt < 100) begin
         tick(1);
         cnt++;
         cross_req <= (cnt == 5);
      end
      `CHK(cnt, OS)
      wr(IDX_RING_MODE, 32'h0);
      wr(IDX_RING_CFG, 32'h0);
      // ring rise latched, masked, then raised and cleared
      rd(IDX_IRQ_STATUS); `CHK(rdv, 32'h1)
      `CHK(irq, 1'b0)
      wr(IDX_IRQ_MASK, 32'h3);
      tick(2);
      `CHK(irq, 1'b1)
      wr(IDX_IRQ_STATUS, 32'h1);
      tick(2);
      `CHK(irq, 1'b0)
      // dropout: read-only, set by detection only
      wr(IDX_DROPOUT, 32'h2);
      rd(IDX_DROPOUT);    `CHK(rdv[1], 1'b0)
      drop_req <= 1'b1;
      tick(1);
      drop_req <= 1'b0;
      tick(3);
      rd(IDX_DROPOUT);    `CHK(rdv[1], 1'b1)
      rd(IDX_IRQ_STATUS); `CHK(rdv, 32'h2)
      `CHK(irq, 1'b1)
      wr(IDX_IRQ_MASK, 32'h1);
      tick(2);
      `CHK(irq, 1'b0)
      // receive path gain per code, transmit muted
      rx_amp <= 16'sd1000;
      for (m = 0; m < 6; m++) begin
         wr(IDX_MON_RX, {24'h0, codes[m]});
         tick(4);
         `CHK(call_progress_out, scale(1000, int'(codes[m])))
      end
      // transmit path gain per code, receive muted
      wr(IDX_MON_RX, 32'h0);
      tx_amp <= -16'sd1000;
      for (m = 0; m < 6; m++) begin
         wr(IDX_MON_TX, {24'h0, codes[m]});
         tick(4);
         `CHK(call_progress_out, scale(-1000, int'(codes[m])))
      end
      rd(IDX_MON_TX);     `CHK(rdv, 32'h30)
      // both paths summed
      wr(IDX_MON_RX, 32'h40);
      wr(IDX_MON_TX, 32'h20);
      tick(4);
      `CHK(call_progress_out, 16'sd500)
      report_and_stop();
   end

   initial begin
      #2_000_000;
      n_mismatch++;
      $display("unexpected at %0t ns: run too long", $time);
      report_and_stop();
   end
endmodule : ring_mode_and_monitor_level_regs_tb
